/* rgbsh_pkg.sv */
// Shared constants and types of the RGB sensor host interface
package rgbsh_pkg;
    // Timing
    localparam int CLK_HZ      = 10_000_000;
    localparam int T_INT16_MS  = 100;
    localparam int INT16_CYC   = T_INT16_MS * (CLK_HZ / 1000);
    localparam int INT12_CYC   = INT16_CYC / 16;
    localparam int T_PWRUP_US  = 20;
    localparam int PWRUP_CYC   = T_PWRUP_US * (CLK_HZ / 1_000_000);
    localparam int T_WRCYC_US  = 10;
    localparam int WRCYC_CYC   = T_WRCYC_US * (CLK_HZ / 1_000_000);
    localparam int SEQ_W       = 16;

    // Bus identity and commands
    localparam logic [6:0] BUS_ID       = 7'h44;
    localparam logic [7:0] DEV_ID_DFLT  = 8'hA5; // Arbitrary value
    localparam logic [7:0] SOFT_RST_CMD = 8'h46;

    // Register addresses
    localparam logic [3:0] A_ID    = 4'h0;
    localparam logic [3:0] A_CFG1  = 4'h1;
    localparam logic [3:0] A_CFG2  = 4'h2;
    localparam logic [3:0] A_CFG3  = 4'h3;
    localparam logic [3:0] A_THL_L = 4'h4;
    localparam logic [3:0] A_THL_H = 4'h5;
    localparam logic [3:0] A_THH_L = 4'h6;
    localparam logic [3:0] A_THH_H = 4'h7;
    localparam logic [3:0] A_STAT  = 4'h8;
    localparam logic [3:0] A_GRN_L = 4'h9;
    localparam logic [3:0] A_GRN_H = 4'hA;
    localparam logic [3:0] A_RED_L = 4'hB;
    localparam logic [3:0] A_RED_H = 4'hC;
    localparam logic [3:0] A_BLU_L = 4'hD;
    localparam logic [3:0] A_BLU_H = 4'hE;
    localparam logic [3:0] A_LAST  = 4'hE;

    // Field positions
    localparam int CFG1_RNG  = 3;
    localparam int CFG1_RES  = 4;
    localparam int CFG1_SYNC = 5;
    localparam int STAT_FLAG = 0;
    localparam int STAT_CONV = 1;
    localparam int STAT_BOUT = 2;

    // Modes and reset values
    localparam logic [2:0]  MODE_PDN   = 3'h0;
    localparam logic [2:0]  MODE_STBY  = 3'h4;
    localparam logic [7:0]  CFG_RST    = 8'h00;
    localparam logic [15:0] THL_RST    = 16'h0000;
    localparam logic [15:0] THH_RST    = 16'hFFFF;
    localparam logic [15:0] DATA_RST   = 16'h0000;
    localparam logic [15:0] RES12_MASK = 16'h0FFF;

    // Serial bit positions within a nine-clock byte
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT  = 4'h8;

    typedef enum logic [2:0] {
        PH_ADDR = 3'h0,
        PH_REG  = 3'h1,
        PH_WR   = 3'h3,
        PH_RD   = 3'h2,
        PH_SKIP = 3'h6
    } rgbsh_phase_e;

    typedef enum logic [1:0] {
        EV_PTR  = 2'h0,
        EV_WR   = 2'h1,
        EV_LD   = 2'h3,
        EV_DONE = 2'h2
    } rgbsh_event_e;
endpackage

/* rgbsh_integ.sv */
// Integration period timer of the converter
`timescale 1ns/1ps
module rgbsh_integ
    import rgbsh_pkg::*;
#(
    parameter int C16 = INT16_CYC,
    parameter int C12 = INT12_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Control
    input  wire logic start,
    input  wire logic run,
    input  wire logic res16,
    input  wire logic continuous,
    // Status
    output logic      busy_q,
    output logic      done_q
);
    localparam int CW = $clog2(C16 + 1);

    logic [CW-1:0] cnt_q;
    wire  [CW-1:0] last_w = res16 ? CW'(C16 - 1) : CW'(C12 - 1);

    always_ff @(posedge clk) begin
        if (sys_rst || !run) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            cnt_q  <= '0;
        end else begin
            done_q <= busy_q && (cnt_q == last_w);
            if (busy_q && cnt_q == last_w) begin
                busy_q <= continuous;
                cnt_q  <= '0;
            end else if (busy_q) begin
                cnt_q <= cnt_q + CW'(1);
            end else if (start) begin
                busy_q <= 1'b1;
                cnt_q  <= '0;
            end
        end
    end
endmodule // rgbsh_integ

/* rgbsh_link.sv */
// Serial slave running on the bus clock
`timescale 1ns/1ps
module rgbsh_link
    import rgbsh_pkg::*;
(
    // Bus clock and clear
    input  wire logic       scl_clk,
    input  wire logic       link_clr,
    // Data line
    input  wire logic       sda_i,
    output logic            sda_oe_n_q,
    // Register side
    input  wire logic [7:0] rd_byte,
    output logic            ev_tgl_q,
    output rgbsh_event_e    ev_kind_q,
    output logic [7:0]      ev_data_q
);
    logic         sda_p_q;
    logic         mack_q;
    logic [7:0]   sh_q;
    logic [7:0]   tx_q;
    logic [3:0]   cnt_q;
    rgbsh_phase_e ph_q;

    wire restart_w = sda_p_q && !sda_i;

    // Sample on the rising edge, MSB first
    always_ff @(posedge scl_clk or posedge link_clr) begin
        if (link_clr) begin
            sda_p_q <= 1'b1;
            sh_q    <= 8'h00;
            mack_q  <= 1'b1;
        end else begin
            sda_p_q <= sda_i;
            if (cnt_q != ACK_BIT) begin
                sh_q <= {sh_q[6:0], sda_i};
            end else begin
                mack_q <= sda_i;
            end
        end
    end

    always_ff @(negedge scl_clk or posedge link_clr) begin
        if (link_clr) begin
            cnt_q      <= 4'h0;
            ph_q       <= PH_ADDR;
            sda_oe_n_q <= 1'b1;
            tx_q       <= 8'h00;
            ev_tgl_q   <= 1'b0;
            ev_kind_q  <= EV_PTR;
            ev_data_q  <= 8'h00;
        end else if (restart_w) begin
            cnt_q      <= 4'h0;
            ph_q       <= PH_ADDR;
            sda_oe_n_q <= 1'b1;
        end else begin
            cnt_q <= (cnt_q == ACK_BIT) ? 4'h0 : cnt_q + 4'h1;
            if (cnt_q == LAST_BIT) begin
                sda_oe_n_q <= 1'b1;
                case (ph_q)
                    PH_ADDR: begin
                        if (sh_q[7:1] == BUS_ID) begin
                            sda_oe_n_q <= 1'b0;
                            ph_q <= sh_q[0] ? PH_RD : PH_REG;
                        end else begin
                            ph_q <= PH_SKIP;
                        end
                    end
                    PH_REG: begin
                        sda_oe_n_q <= 1'b0;
                        ph_q       <= PH_WR;
                        ev_tgl_q   <= ~ev_tgl_q;
                        ev_kind_q  <= EV_PTR;
                        ev_data_q  <= sh_q;
                    end
                    PH_WR: begin
                        sda_oe_n_q <= 1'b0;
                        ev_tgl_q   <= ~ev_tgl_q;
                        ev_kind_q  <= EV_WR;
                        ev_data_q  <= sh_q;
                    end
                    default: sda_oe_n_q <= 1'b1;
                endcase
            end else if (cnt_q == ACK_BIT) begin
                if (ph_q == PH_RD && !mack_q) begin
                    sda_oe_n_q <= rd_byte[7];
                    tx_q       <= {rd_byte[6:0], 1'b1};
                    ev_tgl_q   <= ~ev_tgl_q;
                    ev_kind_q  <= EV_LD;
                end else if (ph_q == PH_RD) begin
                    sda_oe_n_q <= 1'b1;
                    ph_q       <= PH_SKIP;
                    ev_tgl_q   <= ~ev_tgl_q;
                    ev_kind_q  <= EV_DONE;
                end else begin
                    sda_oe_n_q <= 1'b1;
                end
            end else if (ph_q == PH_RD) begin
                sda_oe_n_q <= tx_q[7];
                tx_q       <= {tx_q[6:0], 1'b1};
            end
        end
    end
endmodule // rgbsh_link

/* rgbsh_top.sv */
// Digital core of the three-channel colour light sensor
`timescale 1ns/1ps

// Contract
// - Software picks 12 or 16 bit resolution; conversion time follows it.
// - Integration period comes from oscillator count, about 100 ms at 16 bits.
// - Two sensing ranges, high sensitivity dim and low sensitivity bright.
// - Sync bit set turns the alarm pin into an input.
// - In sync mode each rising alarm pin edge starts a conversion. Edges that arrive while a conversion runs are ignored.
// - Sync bit clear drives alarm pin whenever the window flag is raised.
// - Alarm pin is open drain, active low, never driven high.
// - Conversions continue after alarm; new results overwrite data registers.
// - Alarm raised only after persistence count of out-of-window conversions.
// - Two bits of configuration three select the compared colour channel.
// - Flag when selected count is below low or above high threshold.
// - Raising the flag sets status bit and pulls alarm pin together. The pin is pulled one clock after the status bit.
// - Finishing a bus read of the status byte clears flag and alarm.
// - After power-on reset the device stands by; reset returns it there. Reset loads mode 0, power-down, not standby.
// - STARTs ignored and registers blocked during the power-up sequence.
// - Every serial byte travels most significant bit first.
// - STOP ends access; early STOP abandons it with registers unchanged.
// - Device acknowledges matching address, register address, write data.
// - Address upper seven bits must be 1000100; lowest bit one means read.
// - Byte write is START, address, register, data, all acknowledged, STOP.
// - Internal write cycle after a write ignores inputs and releases data.
// - Burst writes advance the pointer by one, wrapping after the last.
module rgbsh_top
    import rgbsh_pkg::*;
#(
    parameter int         INT16_CYC_P = INT16_CYC,
    parameter int         INT12_CYC_P = INT12_CYC,
    parameter logic [7:0] DEVICE_ID   = DEV_ID_DFLT // Arbitrary value
) (
    // System clock and power-on reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Serial bus
    input  wire logic        scl_clk,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n,
    // Alarm pin
    input  wire logic        alarm_i,
    output logic             alarm_o,
    output logic             alarm_oe_n,
    // Converter front end
    input  wire logic [15:0] grn_count,
    input  wire logic [15:0] red_count,
    input  wire logic [15:0] blu_count,
    output logic             adc_range_hi,
    output logic             adc_res16,
    output logic             adc_busy,
    // Status
    output logic             color_window_flag
);
    // Channel enables {blue, red, green} per operating mode
    function automatic logic [2:0] chan_en(input logic [2:0] mode);
        case (mode)
            3'h1:    chan_en = 3'h1;
            3'h2:    chan_en = 3'h2;
            3'h3:    chan_en = 3'h4;
            3'h5:    chan_en = 3'h7;
            3'h6:    chan_en = 3'h3;
            3'h7:    chan_en = 3'h5;
            default: chan_en = 3'h0;
        endcase
    endfunction

    function automatic logic [3:0] persist_need(input logic [1:0] p);
        case (p)
            2'h0:    persist_need = 4'h1;
            2'h1:    persist_need = 4'h2;
            2'h2:    persist_need = 4'h4;
            default: persist_need = 4'h8;
        endcase
    endfunction

    function automatic logic [3:0] next_ptr(input logic [3:0] p);
        next_ptr = (p >= A_LAST) ? 4'h0 : p + 4'h1;
    endfunction

    function automatic logic [15:0] upd16(
        input logic [15:0] cur,
        input logic        wlo,
        input logic        whi,
        input logic [7:0]  d
    );
        upd16 = cur;
        if (wlo) upd16[7:0] = d;
        if (whi) upd16[15:8] = d;
    endfunction

    // Register state
    logic [7:0]  cfg1_q;
    logic [7:0]  cfg2_q;
    logic [7:0]  cfg3_q;
    logic [15:0] thl_q;
    logic [15:0] thh_q;
    logic [15:0] grn_q;
    logic [15:0] red_q;
    logic [15:0] blu_q;
    logic        flag_q;
    logic        bout_q;
    logic [3:0]  ptr_q;
    logic [3:0]  last_q;
    logic        outst_q;
    logic [7:0]  rd_hold_q;
    logic        rd_upd_q;

    // Bus line watchers and link control
    logic        scl_s1_q;
    logic        scl_s2_q;
    logic        sda_s1_q;
    logic        sda_s2_q;
    logic        sda_s3_q;
    logic        link_clr_q;
    logic        wrote_q;
    logic [SEQ_W-1:0] pwr_cnt_q;
    logic [SEQ_W-1:0] wcyc_cnt_q;
    logic        od_low_q;

    // Event crossing from the link
    logic         ev_tgl;
    rgbsh_event_e ev_kind;
    logic [7:0]   ev_data;
    logic         ev_s1_q;
    logic         ev_s2_q;
    logic         ev_s3_q;

    // Alarm pin input and conversion
    logic        alm_s1_q;
    logic        alm_s2_q;
    logic        alm_s3_q;
    logic        cfg1_wr_q;
    logic        conv_done;
    logic        cmp_q;
    logic [3:0]  pcnt_q;
    logic        alarm_oe_n_q;

    // Decoding
    wire start_det  = scl_s2_q && sda_s3_q && !sda_s2_q;
    wire stop_det   = scl_s2_q && !sda_s3_q && sda_s2_q;
    wire pwr_busy   = pwr_cnt_q != '0;
    wire wcyc_busy  = wcyc_cnt_q != '0;
    // Link clear drops the toggle to zero; that edge is not an event
    wire ev_pulse   = (ev_s2_q ^ ev_s3_q) && !link_clr_q;
    wire ev_ptr     = ev_pulse && ev_kind == EV_PTR;
    wire ev_wr      = ev_pulse && ev_kind == EV_WR;
    wire ev_ld      = ev_pulse && ev_kind == EV_LD;
    wire ev_done    = ev_pulse && ev_kind == EV_DONE;
    wire soft_rst   = ev_wr && ptr_q == A_ID && ev_data == SOFT_RST_CMD;
    wire w_cfg1     = ev_wr && ptr_q == A_CFG1;
    wire w_cfg2     = ev_wr && ptr_q == A_CFG2;
    wire w_cfg3     = ev_wr && ptr_q == A_CFG3;
    wire w_thl_l    = ev_wr && ptr_q == A_THL_L;
    wire w_thl_h    = ev_wr && ptr_q == A_THL_H;
    wire w_thh_l    = ev_wr && ptr_q == A_THH_L;
    wire w_thh_h    = ev_wr && ptr_q == A_THH_H;
    wire w_grn_l    = ev_wr && ptr_q == A_GRN_L;
    wire w_grn_h    = ev_wr && ptr_q == A_GRN_H;
    wire w_red_l    = ev_wr && ptr_q == A_RED_L;
    wire w_red_h    = ev_wr && ptr_q == A_RED_H;
    wire w_blu_l    = ev_wr && ptr_q == A_BLU_L;
    wire w_blu_h    = ev_wr && ptr_q == A_BLU_H;
    wire stat_done  = (ev_ld || ev_done) && outst_q && last_q == A_STAT;
    wire sync_mode  = cfg1_q[CFG1_SYNC];
    wire res16      = cfg1_q[CFG1_RES];
    wire [2:0] mode = cfg1_q[2:0];
    wire [2:0] en   = chan_en(mode);
    wire run        = mode != MODE_PDN && mode != MODE_STBY;
    wire alarm_rise = alm_s2_q && !alm_s3_q;
    wire conv_start = sync_mode ? alarm_rise : cfg1_wr_q;
    wire [15:0] res_mask = res16 ? 16'hFFFF : RES12_MASK;
    wire [15:0] sel_cnt  = (cfg3_q[1:0] == 2'h1) ? grn_q :
                           (cfg3_q[1:0] == 2'h2) ? red_q : blu_q;
    wire out_win    = cfg3_q[1:0] != 2'h0 &&
                      (sel_cnt < thl_q || sel_cnt > thh_q);
    wire [4:0] pcnt_inc = {1'b0, pcnt_q} + 5'h01;
    wire [3:0] need     = persist_need(cfg3_q[3:2]);
    wire flag_set   = cmp_q && out_win && pcnt_inc >= {1'b0, need};
    wire [7:0] stat_byte = {5'h00, bout_q, adc_busy, flag_q};

    function automatic logic [7:0] reg_rd(input logic [3:0] a);
        case (a)
            A_ID:    reg_rd = DEVICE_ID;
            A_CFG1:  reg_rd = cfg1_q;
            A_CFG2:  reg_rd = cfg2_q;
            A_CFG3:  reg_rd = cfg3_q;
            A_THL_L: reg_rd = thl_q[7:0];
            A_THL_H: reg_rd = thl_q[15:8];
            A_THH_L: reg_rd = thh_q[7:0];
            A_THH_H: reg_rd = thh_q[15:8];
            A_STAT:  reg_rd = stat_byte;
            A_GRN_L: reg_rd = grn_q[7:0];
            A_GRN_H: reg_rd = grn_q[15:8];
            A_RED_L: reg_rd = red_q[7:0];
            A_RED_H: reg_rd = red_q[15:8];
            A_BLU_L: reg_rd = blu_q[7:0];
            A_BLU_H: reg_rd = blu_q[15:8];
            default: reg_rd = 8'h00;
        endcase
    endfunction

    // Bus line and alarm pin synchronisers
    always_ff @(posedge clk) begin
        scl_s1_q <= scl_clk;
        scl_s2_q <= scl_s1_q;
        sda_s1_q <= sda_i;
        sda_s2_q <= sda_s1_q;
        sda_s3_q <= sda_s2_q;
        alm_s1_q <= alarm_i;
        alm_s2_q <= alm_s1_q;
        alm_s3_q <= alm_s2_q;
        ev_s1_q  <= ev_tgl;
        ev_s2_q  <= ev_s1_q;
        ev_s3_q  <= ev_s2_q;
        od_low_q <= 1'b0;
    end

    // Power-up and internal write cycle hold the link cleared
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pwr_cnt_q  <= SEQ_W'(PWRUP_CYC);
            wcyc_cnt_q <= '0;
            wrote_q    <= 1'b0;
            link_clr_q <= 1'b1;
        end else begin
            if (pwr_busy) pwr_cnt_q <= pwr_cnt_q - SEQ_W'(1);
            if (stop_det && wrote_q) begin
                wcyc_cnt_q <= SEQ_W'(WRCYC_CYC);
            end else if (wcyc_busy) begin
                wcyc_cnt_q <= wcyc_cnt_q - SEQ_W'(1);
            end
            if (stop_det || start_det) begin
                wrote_q <= 1'b0;
            end else if (ev_wr) begin
                wrote_q <= 1'b1;
            end
            if (pwr_busy || wcyc_busy) begin
                link_clr_q <= 1'b1;
            end else if (stop_det) begin
                link_clr_q <= 1'b1;
            end else if (start_det) begin
                link_clr_q <= 1'b0;
            end
        end
    end

    // Register pointer and read staging
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ptr_q     <= A_ID;
            last_q    <= A_ID;
            outst_q   <= 1'b0;
            rd_upd_q  <= 1'b0;
            rd_hold_q <= 8'h00;
        end else begin
            rd_upd_q <= ev_pulse || start_det;
            if (rd_upd_q) rd_hold_q <= reg_rd(ptr_q);
            if (ev_ptr) begin
                ptr_q <= ev_data[3:0];
            end else if (ev_wr || ev_ld) begin
                ptr_q <= next_ptr(ptr_q);
            end
            if (ev_ld) begin
                last_q  <= ptr_q;
                outst_q <= 1'b1;
            end else if (ev_done || start_det) begin
                outst_q <= 1'b0;
            end
        end
    end

    // Configuration and threshold registers
    always_ff @(posedge clk) begin
        if (sys_rst || soft_rst) begin
            cfg1_q    <= CFG_RST;
            cfg2_q    <= CFG_RST;
            cfg3_q    <= CFG_RST;
            thl_q     <= THL_RST;
            thh_q     <= THH_RST;
            cfg1_wr_q <= 1'b0;
        end else begin
            cfg1_wr_q <= w_cfg1;
            if (w_cfg1) cfg1_q <= ev_data;
            if (w_cfg2) cfg2_q <= ev_data;
            if (w_cfg3) cfg3_q <= ev_data;
            thl_q <= upd16(thl_q, w_thl_l, w_thl_h, ev_data);
            thh_q <= upd16(thh_q, w_thh_l, w_thh_h, ev_data);
        end
    end

    // Data registers, enabled channels refreshed by every conversion
    always_ff @(posedge clk) begin
        if (sys_rst || soft_rst) begin
            grn_q <= DATA_RST;
            red_q <= DATA_RST;
            blu_q <= DATA_RST;
        end else if (conv_done) begin
            if (en[0]) grn_q <= grn_count & res_mask;
            if (en[1]) red_q <= red_count & res_mask;
            if (en[2]) blu_q <= blu_count & res_mask;
        end else begin
            grn_q <= upd16(grn_q, w_grn_l, w_grn_h, ev_data);
            red_q <= upd16(red_q, w_red_l, w_red_h, ev_data);
            blu_q <= upd16(blu_q, w_blu_l, w_blu_h, ev_data);
        end
    end

    // Window compare, persistence and flag
    always_ff @(posedge clk) begin
        if (sys_rst || soft_rst) begin
            cmp_q  <= 1'b0;
            pcnt_q <= 4'h0;
            flag_q <= 1'b0;
            bout_q <= 1'b1;
        end else begin
            cmp_q <= conv_done;
            if (cmp_q && out_win) begin
                if (pcnt_inc <= 5'h08) pcnt_q <= pcnt_inc[3:0];
            end else if (cmp_q) begin
                pcnt_q <= 4'h0;
            end
            if (flag_set) begin
                flag_q <= 1'b1;
            end else if (stat_done) begin
                flag_q <= 1'b0;
            end
            if (stat_done) bout_q <= 1'b0;
        end
    end

    // Alarm pin drive, released in sync mode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            alarm_oe_n_q <= 1'b1;
        end else begin
            alarm_oe_n_q <= !(flag_q && !sync_mode);
        end
    end

    rgbsh_integ #(
        .C16        (INT16_CYC_P),
        .C12        (INT12_CYC_P)
    ) u_integ (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .start      (conv_start),
        .run        (run),
        .res16      (res16),
        .continuous (!sync_mode),
        .busy_q     (adc_busy),
        .done_q     (conv_done)
    );

    rgbsh_link u_link (
        .scl_clk    (scl_clk),
        .link_clr   (link_clr_q),
        .sda_i      (sda_i),
        .sda_oe_n_q (sda_oe_n),
        .rd_byte    (rd_hold_q),
        .ev_tgl_q   (ev_tgl),
        .ev_kind_q  (ev_kind),
        .ev_data_q  (ev_data)
    );

    assign sda_o             = od_low_q;
    assign alarm_o           = od_low_q;
    assign alarm_oe_n        = alarm_oe_n_q;
    assign adc_range_hi      = cfg1_q[CFG1_RNG];
    assign adc_res16         = cfg1_q[CFG1_RES];
    assign color_window_flag = flag_q;
endmodule // rgbsh_top

/* rgbsh_top_asserts.sv */
// Port checks of the sensor host interface
`timescale 1ns/1ps
module rgbsh_top_asserts
    import rgbsh_pkg::*;
#(
    parameter int INT16_CYC_P = INT16_CYC,
    parameter int INT12_CYC_P = INT12_CYC
) (
    // Clocks, reset and pins
    input wire logic clk, sys_rst, scl_clk, sda_i, sda_o, sda_oe_n,
    input wire logic alarm_i, alarm_o, alarm_oe_n,
    // Converter and status
    input wire logic [15:0] grn_count, red_count, blu_count,
    input wire logic adc_range_hi, adc_res16, adc_busy, color_window_flag
);
    logic [8:0] pwr_q;
    always_ff @(posedge clk) begin
        if (sys_rst) pwr_q <= 9'h000;
        else if (pwr_q != 9'h1FF) pwr_q <= pwr_q + 9'h001;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_idle;
        sda_oe_n && alarm_oe_n && !color_window_flag && !adc_busy;
    endsequence
    chk_reset_idle: assert property ($fell(sys_rst) |-> s_idle)
        else $error("not idle after reset");
    chk_pwrup_quiet: assert property (pwr_q < PWRUP_CYC |-> sda_oe_n)
        else $error("ack in power-up");
    chk_alarm_low: assert property (alarm_o == 1'b0)
        else $error("alarm driven high");
    chk_sda_low: assert property (sda_o == 1'b0)
        else $error("data driven high");
    chk_alarm_flag: assert property (
        !alarm_oe_n |-> color_window_flag || $past(color_window_flag))
        else $error("alarm without flag");
    chk_flag_clear: assert property (
        $fell(color_window_flag) |-> ##[0:2] alarm_oe_n)
        else $error("alarm kept");
    chk_busy_hold: assert property ($rose(adc_busy) |=> adc_busy [*8])
        else $error("integration short");
    chk_sda_steady: assert property (
        scl_clk && $past(scl_clk) |-> $stable(sda_oe_n))
        else $error("data moved with clock high");
endmodule // rgbsh_top_asserts

bind rgbsh_top rgbsh_top_asserts #(.INT16_CYC_P(INT16_CYC_P),
    .INT12_CYC_P(INT12_CYC_P)) i_rgbsh_top_asserts (.clk, .sys_rst,
    .scl_clk, .sda_i, .sda_o, .sda_oe_n, .alarm_i, .alarm_o, .alarm_oe_n,
    .grn_count, .red_count, .blu_count, .adc_range_hi, .adc_res16,
    .adc_busy, .color_window_flag);

/* rgbsh_master.sv */
// Serial bus master model
`timescale 1ns/1ps
module rgbsh_master (
    // Bus lines
    output logic      scl,
    output logic      sda_m,
    input  wire logic sda
);
    initial {scl, sda_m} = 2'h3;
    task automatic bit_io(input logic b, output logic r);
        #100 sda_m = b;
        #300 scl = 1'b1;
        r = sda;
        #400 scl = 1'b0;
    endtask
    // Start is (1, 0), stop is (0, 1); clock idles high after stop
    task automatic cond(input logic a, input logic b);
        #100 sda_m = a;
        #300 scl = 1'b1;
        #400 sda_m = b;
        #400 scl = b;
    endtask
    task automatic xfer(input logic [7:0] d, input logic m,
                        output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(m, ack);
    endtask
    task automatic op(input logic [7:0] r, d, input logic rdn,
                      output logic [7:0] q, output logic [2:0] k);
        logic z;
        cond(1'b1, 1'b0);
        xfer(8'h88, 1'b1, q, k[2]);
        xfer(r, 1'b1, q, k[1]);
        if (rdn) begin
            cond(1'b1, 1'b0);
            xfer(8'h89, 1'b1, q, k[0]);
            xfer(8'hFF, 1'b1, q, z);
        end
        else xfer(d, 1'b1, q, k[0]);
        cond(1'b0, 1'b1);
    endtask
endmodule // rgbsh_master

/* test_rgb_sensor_host_interface.sv */
// Self-checking bench of the sensor host interface
`timescale 1ns/1ps
module test_rgb_sensor_host_interface;
    import rgbsh_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, alarm_d = 1'b1;
    logic scl_clk, sda_m, sda_o, sda_oe_n, alarm_o, alarm_oe_n;
    logic adc_range_hi, adc_res16, adc_busy, flag;
    logic [15:0] cnt = 16'h0300;
    logic [7:0] q;
    logic [2:0] k;
    int err_total = 0, checks_done = 0, n;
    // Register and byte written, read back unchanged
    logic [15:0] rows [6] = '{16'h0400, 16'h0501, 16'h0600, 16'h0702,
        16'h0301, 16'h011D};
    wire sda_i = sda_m & sda_oe_n;
    wire alarm_i = alarm_d & alarm_oe_n;
    rgbsh_top #(.INT16_CYC_P(64), .INT12_CYC_P(16)) i_rgbsh_top (.clk,
        .sys_rst, .scl_clk, .sda_i, .sda_o, .sda_oe_n, .alarm_i, .alarm_o,
        .alarm_oe_n, .grn_count(cnt), .red_count(cnt), .blu_count(cnt),
        .adc_range_hi, .adc_res16, .adc_busy, .color_window_flag(flag));
    rgbsh_master i_rgbsh_master (.scl(scl_clk), .sda_m, .sda(sda_i));
    initial forever #50 clk = ~clk;
    task automatic chk(input logic [15:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %h, not %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("%0d checks, %0d mismatches", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Full frame, then the write cycle gap
    task automatic acc(input logic [7:0] r, d, input logic rdn);
        i_rgbsh_master.op(r, d, rdn, q, k);
        chk(k, 3'h0);
        #10000;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk({sda_oe_n, alarm_oe_n, flag, adc_busy}, 4'hC);
        i_rgbsh_master.op(8'h01, 8'h05, 1'b0, q, k);
        chk(k[2], 1'b1);
        #10000;
        $display("test reset done");
        foreach (rows[i]) begin
            acc(rows[i][15:8], rows[i][7:0], 1'b0);
            acc(rows[i][15:8], 8'h00, 1'b1);
            chk(q, rows[i][7:0]);
        end
        chk({adc_range_hi, adc_res16}, 2'h3);
        for (n = 0; n < 500 && flag !== 1'b1; n++) @(negedge clk);
        chk({flag, alarm_oe_n}, 2'h2);
        if (flag !== 1'b1) test_done;
        @(posedge clk) cnt <= 16'h0150;
        #8000;
        acc({4'h0, A_STAT}, 8'h00, 1'b1);
        chk({q[0], flag, alarm_oe_n}, 3'h5);
        acc({4'h0, A_GRN_L}, 8'h00, 1'b1);
        chk(q, 8'h50);
        $display("test alarm done");
        i_rgbsh_master.cond(1'b1, 1'b0);
        i_rgbsh_master.xfer(8'h8A, 1'b1, q, k[0]);
        chk(k[0], 1'b1);
        i_rgbsh_master.cond(1'b1, 1'b0);
        i_rgbsh_master.xfer(8'h88, 1'b1, q, k[0]);
        i_rgbsh_master.xfer(8'h04, 1'b1, q, k[0]);
        repeat (4) i_rgbsh_master.bit_io(1'b1, k[0]);
        i_rgbsh_master.cond(1'b0, 1'b1);
        i_rgbsh_master.op(8'h04, 8'h00, 1'b0, q, k);
        i_rgbsh_master.op(8'h04, 8'h77, 1'b0, q, k);
        chk(k[2], 1'b1);
        acc(8'h04, 8'h00, 1'b1);
        chk(q, 8'h00);
        $display("test stop done");
        acc(8'h01, 8'h3D, 1'b0);
        chk({adc_busy, alarm_oe_n}, 2'h1);
        @(posedge clk) alarm_d <= 1'b0;
        @(posedge clk) alarm_d <= 1'b1;
        for (n = 0; n < 20 && adc_busy !== 1'b1; n++) @(negedge clk);
        chk(adc_busy, 1'b1);
        $display("test sync done");
        @(posedge clk) sys_rst <= 1'b1;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk({adc_range_hi, adc_res16, adc_busy, alarm_oe_n}, 4'h1);
        $display("test late reset done");
        test_done;
    end
endmodule // test_rgb_sensor_host_interface
